// ---- hw/ppfi_top.sv ----
// Parallel programming port with fuses, lock, signature and calibration
`timescale 1ns/1ps
`include "ppfi_cfg.svh"
module ppfi_top
#(
	parameter int          MEM_AW   = 8,
	parameter int          PAGE_BITS = 2,
	parameter logic [7:0]  SIG_MAKER = 8'h5A,
	parameter logic [7:0]  SIG_SIZE  = 8'hA5,
	parameter logic [7:0]  SIG_PART  = 8'h3C,
	parameter logic [7:0]  CAL_BYTE  = 8'h80
)
(
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	input  wire logic       prog_mode_i,
	input  wire logic       serial_mode_i,
	input  wire logic       load_strobe_i,
	input  wire logic       strobe_action_bit0_i,
	input  wire logic       strobe_action_bit1_i,
	input  wire logic       byte_select_one_i,
	input  wire logic       byte_select_two_i,
	input  wire logic       write_n_i,
	input  wire logic       output_enable_n_i,
	input  wire logic       page_load_pulse_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic      [7:0] data_oe_n_o,
	output logic            ready_busy_out_o,
	output logic            prog_entered_o,
	output logic      [7:0] active_ext_fuse_o,
	output logic      [7:0] active_high_fuse_o,
	output logic      [7:0] active_low_fuse_o,
	output logic            eeprom_preserve_o,
	output logic      [7:0] rc_osc_calibration_o
);
	import ppfi_pkg::*;

	initial
	begin
		if (MEM_AW < PAGE_BITS + 1 || MEM_AW > 16 || PAGE_BITS < 1)
			$error("ppfi_top memory geometry not supported");
	end

	// Pins come from the programmer, so all are synchronised
	logic [14:0] pins_s;
	ppfi_sync #(.WIDTH(15)) u_sync
	(
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.async_i   ({prog_mode_i, serial_mode_i, load_strobe_i,
			strobe_action_bit0_i, strobe_action_bit1_i,
			byte_select_one_i, byte_select_two_i, write_n_i,
			output_enable_n_i, page_load_pulse_i, data_i[4:0]}),
		.sync_o    (pins_s)
	);
	logic [2:0] data_hi_s;
	ppfi_sync #(.WIDTH(3)) u_sync_hi
	(
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.async_i   (data_i[7:5]),
		.sync_o    (data_hi_s)
	);

	logic       prog_s, serial_s, strobe_s, xa0_s, xa1_s, bs1_s, bs2_s;
	logic       wr_n_s, oe_n_s, page_load_pulse_s;
	logic [7:0] din_s;
	assign {prog_s, serial_s, strobe_s, xa0_s, xa1_s, bs1_s, bs2_s,
		wr_n_s, oe_n_s, page_load_pulse_s} = pins_s[14:5];
	assign din_s = {data_hi_s, pins_s[4:0]};

	// Edge detectors on synchronised pins
	logic strobe_d1_q, wr_d1_q, page_load_pulse_d1_q, prog_d1_q;
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			strobe_d1_q <= 1'b0;
			wr_d1_q     <= 1'b0; // Synchroniser resets low: no false edge
			page_load_pulse_d1_q  <= 1'b0;
			prog_d1_q   <= 1'b0;
		end
		else
		begin
			strobe_d1_q <= strobe_s;
			wr_d1_q     <= wr_n_s;
			page_load_pulse_d1_q  <= page_load_pulse_s;
			prog_d1_q   <= prog_s;
		end
	end
	logic strobe_rise, wr_fall, page_load_pulse_rise, prog_rise, prog_fall;
	assign strobe_rise = strobe_s & ~strobe_d1_q;
	assign wr_fall     = ~wr_n_s & wr_d1_q;
	assign page_load_pulse_rise  = page_load_pulse_s & ~page_load_pulse_d1_q;
	assign prog_rise   = prog_s & ~prog_d1_q;
	assign prog_fall   = ~prog_s & prog_d1_q;

	ppfi_state_type state_q;
	logic [7:0] cmd_q, addr_lo_q, addr_hi_q, dat_lo_q, dat_hi_q;

	// Command, address and data latches hold until reloaded
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cmd_q     <= 8'h00;
			addr_lo_q <= 8'h00;
			addr_hi_q <= 8'h00;
			dat_lo_q  <= 8'hFF;
			dat_hi_q  <= 8'hFF;
		end
		else if (strobe_rise && prog_s && state_q == PPFI_ST_IDLE)
		begin
			case (ppfi_action_type'({xa1_s, xa0_s}))
				PPFI_ACT_ADDR:
					if (bs1_s) addr_hi_q <= din_s;
					else addr_lo_q <= din_s;
				PPFI_ACT_DATA:
					if (bs1_s) dat_hi_q <= din_s;
					else dat_lo_q <= din_s;
				PPFI_ACT_CMD:  cmd_q <= din_s;
				default:       ;
			endcase
		end
	end

	// Stored fuse bytes and lock byte; erase never touches fuses
	logic [7:0] fuse_ext_q, fuse_high_q, fuse_low_q, lock_q;
	logic fuse_wr, lock_blocked;
	assign lock_blocked = ~lock_q[`PPFI_BIT_LOCK1];
	assign fuse_wr = wr_fall && prog_s && state_q == PPFI_ST_IDLE &&
		cmd_q == `PPFI_CMD_WR_FUSE && !lock_blocked;
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			fuse_ext_q  <= `PPFI_FUSE_EXT_RST;
			fuse_high_q <= `PPFI_FUSE_HIGH_RST;
			fuse_low_q  <= `PPFI_FUSE_LOW_RST;
		end
		else if (fuse_wr)
		begin
			if (bs1_s && !bs2_s)
			begin
				fuse_high_q <= dat_lo_q; // Latched byte, not live pins
				// Serial mode may not change its own enable
				if (serial_s)
					fuse_high_q[`PPFI_BIT_SERIAL] <=
						fuse_high_q[`PPFI_BIT_SERIAL];
			end
			else if (bs2_s)
				fuse_ext_q <= dat_lo_q | `PPFI_EXT_UNUSED;
			else
				fuse_low_q <= dat_lo_q;
		end
	end

	// Busy sequencer; erase walks every memory cell
	logic [MEM_AW-1:0] op_cnt_q;
	logic              erase_q, mem_wr_q, lock_wr;
	logic [7:0]        pbuf_q [0:(1<<PAGE_BITS)-1];
	assign lock_wr = wr_fall && prog_s && state_q == PPFI_ST_IDLE &&
		cmd_q == `PPFI_CMD_WR_LOCK;
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q  <= PPFI_ST_IDLE;
			op_cnt_q <= '0;
			erase_q  <= 1'b0;
			lock_q   <= `PPFI_LOCK_RST;
		end
		else
		begin
			case (state_q)
				PPFI_ST_IDLE:
				begin
					if (lock_wr)
						lock_q <= lock_q & dat_lo_q;
					if (wr_fall && prog_s && (cmd_q == `PPFI_CMD_ERASE ||
						cmd_q == `PPFI_CMD_WR_FLASH ||
						cmd_q == `PPFI_CMD_WR_EEPROM ||
						cmd_q == `PPFI_CMD_WR_FUSE || lock_wr))
					begin
						erase_q  <= cmd_q == `PPFI_CMD_ERASE;
						op_cnt_q <= '0;
						state_q  <= cmd_q == `PPFI_CMD_ERASE ?
							PPFI_ST_CLEAR : PPFI_ST_BUSY;
					end
				end
				PPFI_ST_BUSY:
				begin
					op_cnt_q <= op_cnt_q + 1'b1;
					if (op_cnt_q == MEM_AW'(`PPFI_OP_CYC - 1))
						state_q <= PPFI_ST_IDLE;
				end
				PPFI_ST_CLEAR:
				begin
					op_cnt_q <= op_cnt_q + 1'b1;
					// Lock clears on the same edge that erases the last cell
					if (&op_cnt_q)
					begin
						lock_q  <= `PPFI_LOCK_RST;
						erase_q <= 1'b0;
						state_q <= PPFI_ST_IDLE;
					end
				end
				default: state_q <= PPFI_ST_IDLE;
			endcase
		end
	end
	assign ready_busy_out_o = state_q == PPFI_ST_IDLE;

	// Page buffer loads on page-load rising edge
	logic [PAGE_BITS-1:0] word_idx;
	assign word_idx = addr_lo_q[PAGE_BITS-1:0];
	always_ff @(posedge ref_clk_i)
	begin
		if (page_load_pulse_rise && prog_s)
			pbuf_q[word_idx] <= (cmd_q == `PPFI_CMD_WR_FLASH && bs1_s) ?
				dat_hi_q : dat_lo_q;
	end

	// Page write streams the buffer into memory during busy cycles
	logic [MEM_AW-1:0] mem_addr, page_base;
	logic              flash_wr, ee_wr, flash_clr, ee_clr;
	assign page_base = MEM_AW'({addr_hi_q, addr_lo_q}) &
		~MEM_AW'((1 << PAGE_BITS) - 1);
	assign mem_addr = (state_q == PPFI_ST_CLEAR) ? op_cnt_q :
		(state_q == PPFI_ST_BUSY) ?
		(page_base | MEM_AW'(op_cnt_q[PAGE_BITS-1:0])) :
		MEM_AW'({addr_hi_q, addr_lo_q});
	assign mem_wr_q = state_q == PPFI_ST_BUSY &&
		op_cnt_q < MEM_AW'(1 << PAGE_BITS);
	assign flash_wr  = mem_wr_q && cmd_q == `PPFI_CMD_WR_FLASH;
	assign ee_wr     = mem_wr_q && cmd_q == `PPFI_CMD_WR_EEPROM;
	assign flash_clr = erase_q && state_q == PPFI_ST_CLEAR;
	assign ee_clr    = flash_clr && eeprom_preserve_o;

	logic [7:0] flash_rd, ee_rd;
	ppfi_mem #(.AW(MEM_AW)) u_flash
	(
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.wr_en_i   (flash_wr),
		.wr_addr_i (mem_addr),
		.wr_data_i (pbuf_q[op_cnt_q[PAGE_BITS-1:0]]),
		.clr_i     (flash_clr),
		.rd_addr_i (mem_addr),
		.rd_data_o (flash_rd)
	);
	ppfi_mem #(.AW(MEM_AW)) u_eeprom
	(
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.wr_en_i   (ee_wr),
		.wr_addr_i (mem_addr),
		.wr_data_i (pbuf_q[op_cnt_q[PAGE_BITS-1:0]]),
		.clr_i     (ee_clr),
		.rd_addr_i (mem_addr),
		.rd_data_o (ee_rd)
	);

	// Active fuse copies latch on entry and after exit
	logic first_q;
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			first_q            <= 1'b1;
			active_ext_fuse_o  <= `PPFI_FUSE_EXT_RST;
			active_high_fuse_o <= `PPFI_FUSE_HIGH_RST;
			active_low_fuse_o  <= `PPFI_FUSE_LOW_RST;
		end
		else
		begin
			first_q <= 1'b0;
			if ((first_q && !prog_s) || prog_rise || prog_fall)
			begin
				active_ext_fuse_o  <= fuse_ext_q;
				active_high_fuse_o <= fuse_high_q;
				active_low_fuse_o  <= fuse_low_q;
			end
		end
	end
	// Preserve bit bypasses the latch; low means programmed
	assign eeprom_preserve_o = fuse_high_q[`PPFI_BIT_EEPROM_PRESERVE];
	assign prog_entered_o = prog_d1_q;

	// Calibration register loaded while reset is applied
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
			rc_osc_calibration_o <= CAL_BYTE;
		else
			rc_osc_calibration_o <= rc_osc_calibration_o;
	end

	// Read mux; signature ignores lock state
	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = 8'hFF;
		if (cmd_q == `PPFI_CMD_RD_SIG)
		begin
			if (bs1_s)
				rd_byte = CAL_BYTE;
			else if (addr_lo_q == `PPFI_SIG_ADDR0)
				rd_byte = SIG_MAKER;
			else if (addr_lo_q == `PPFI_SIG_ADDR1)
				rd_byte = SIG_SIZE;
			else if (addr_lo_q == `PPFI_SIG_ADDR2)
				rd_byte = SIG_PART;
		end
		else if (cmd_q == `PPFI_CMD_RD_FUSE)
		begin
			if (bs1_s && bs2_s)
				rd_byte = lock_q;
			else if (bs1_s)
				rd_byte = fuse_high_q;
			else if (bs2_s)
				rd_byte = fuse_ext_q;
			else
				rd_byte = fuse_low_q;
		end
		else if (cmd_q == `PPFI_CMD_RD_FLASH)
			rd_byte = lock_q[`PPFI_BIT_LOCK2] ? flash_rd : 8'hFF;
		else if (cmd_q == `PPFI_CMD_RD_EEPROM)
			rd_byte = lock_q[`PPFI_BIT_LOCK2] ? ee_rd : 8'hFF;
	end

	// Bus driven only while output enable is low
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			data_o      <= 8'h00;
			data_oe_n_o <= 8'hFF;
		end
		else
		begin
			data_o      <= rd_byte;
			data_oe_n_o <= {8{~(prog_s & ~oe_n_s)}};
		end
	end
endmodule

// ---- hw/ppfi_cfg.svh ----
// Constants for the parallel programming fuse interface
`ifndef PPFI_CFG_SVH
`define PPFI_CFG_SVH
`define PPFI_FUSE_EXT_RST   8'hFF
`define PPFI_FUSE_HIGH_RST  8'h99
`define PPFI_FUSE_LOW_RST   8'h62
`define PPFI_LOCK_RST       8'hFF
`define PPFI_EXT_UNUSED     8'hF8
`define PPFI_BIT_BOD_HI     2
`define PPFI_BIT_BOD_LO     1
`define PPFI_BIT_RST_DIS    0
`define PPFI_BIT_OCD        7
`define PPFI_BIT_SCAN       6
`define PPFI_BIT_SERIAL     5
`define PPFI_BIT_WDT        4
`define PPFI_BIT_EEPROM_PRESERVE     3
`define PPFI_BIT_BOOT_HI    2
`define PPFI_BIT_BOOT_LO    1
`define PPFI_BIT_RSTVEC     0
`define PPFI_BIT_CLOCK_DIV_BY_EIGHT     7
`define PPFI_BIT_CLOCK_OUTPUT_ENABLE      6
`define PPFI_BIT_SUT_HI     5
`define PPFI_BIT_SUT_LO     4
`define PPFI_BIT_CKSEL_HI   3
`define PPFI_BIT_CKSEL_LO   0
`define PPFI_BIT_LOCK1      0
`define PPFI_BIT_LOCK2      1
`define PPFI_CMD_ERASE      8'h80
`define PPFI_CMD_WR_FUSE    8'h40
`define PPFI_CMD_WR_LOCK    8'h20
`define PPFI_CMD_WR_FLASH   8'h10
`define PPFI_CMD_WR_EEPROM  8'h11
`define PPFI_CMD_RD_SIG     8'h08
`define PPFI_CMD_RD_FUSE    8'h04
`define PPFI_CMD_RD_FLASH   8'h02
`define PPFI_CMD_RD_EEPROM  8'h03
`define PPFI_SIG_ADDR0      8'h00
`define PPFI_SIG_ADDR1      8'h01
`define PPFI_SIG_ADDR2      8'h02
`define PPFI_PULSE_MIN_NS   250
`define PPFI_CLK_PERIOD_NS  10
`define PPFI_PULSE_CYC      ((`PPFI_PULSE_MIN_NS+`PPFI_CLK_PERIOD_NS-1)/`PPFI_CLK_PERIOD_NS)
`define PPFI_OP_CYC         16
`endif

// ---- hw/ppfi_pkg.sv ----
// Types for the parallel programming fuse interface
package ppfi_pkg;
	typedef enum logic [1:0]
	{
		PPFI_ACT_ADDR = 2'b00,
		PPFI_ACT_DATA = 2'b01,
		PPFI_ACT_CMD  = 2'b10,
		PPFI_ACT_IDLE = 2'b11
	} ppfi_action_type;
	typedef enum logic [1:0]
	{
		PPFI_ST_IDLE  = 2'b00,
		PPFI_ST_BUSY  = 2'b01,
		PPFI_ST_CLEAR = 2'b10
	} ppfi_state_type;
endpackage

// ---- hw/ppfi_sync.sv ----
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module ppfi_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	initial
	begin
		if (WIDTH < 1)
			$error("ppfi_sync width must be positive");
	end

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ---- hw/ppfi_mem.sv ----
// Small byte memory with registered read data
`timescale 1ns/1ps
module ppfi_mem
#(
	parameter int AW = 8
)
(
	input  wire logic          ref_clk_i,
	input  wire logic          reset_i,
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [7:0]    wr_data_i,
	input  wire logic          clr_i,
	input  wire logic [AW-1:0] rd_addr_i,
	output logic      [7:0]    rd_data_o
);
	logic [7:0] mem_q [0:(1<<AW)-1];

	initial
	begin
		if (AW < 1 || AW > 16)
			$error("ppfi_mem address width out of range");
	end

	// Erase writes one cell per cycle, the caller walks addresses
	always_ff @(posedge ref_clk_i)
	begin
		if (clr_i)
			mem_q[wr_addr_i] <= 8'hFF;
		else if (wr_en_i)
			mem_q[wr_addr_i] <= wr_data_i;
	end

	// Registered read port
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
			rd_data_o <= 8'hFF;
		else
			rd_data_o <= mem_q[rd_addr_i];
	end
endmodule

// ---- test/ppfi_top_monitor.sv ----
// Checker bound to the programming port top level
`timescale 1ns/1ps
module ppfi_top_monitor
#(
	parameter logic [7:0] CAL_BYTE = 8'h80
)
(
	input wire logic       ref_clk_i,
	input wire logic       reset_i,
	input wire logic       output_enable_n_i,
	input wire logic [7:0] data_oe_n_o,
	input wire logic       ready_busy_out_o,
	input wire logic       prog_entered_o,
	input wire logic [7:0] active_ext_fuse_o,
	input wire logic [7:0] active_high_fuse_o,
	input wire logic [7:0] active_low_fuse_o,
	input wire logic       eeprom_preserve_o,
	input wire logic [7:0] rc_osc_calibration_o
);
	logic [9:0] busy_len_q;
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);
	// Busy stretch length, saturating so it never wraps
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i || ready_busy_out_o)
			busy_len_q <= 10'h000;
		else if (busy_len_q != 10'h3FF)
			busy_len_q <= busy_len_q + 10'h001;
	end
	chk_oe_uniform:
		assert property (data_oe_n_o == 8'h00 || data_oe_n_o == 8'hFF)
		else $error("enables split");
	chk_oe_drive:
		assert property ($fell(output_enable_n_i) && prog_entered_o
			|-> ##[1:6] data_oe_n_o == 8'h00) else $error("bus not driven");
	chk_busy_min:
		assert property ($rose(ready_busy_out_o) |-> busy_len_q >= 10'h010)
		else $error("busy too short");
	chk_busy_max:
		assert property (!ready_busy_out_o |-> busy_len_q < 10'h190)
		else $error("busy too long");
	chk_fuse_hold:
		assert property (prog_entered_o && $past(prog_entered_o, 2) |->
			$stable(active_low_fuse_o) && $stable(active_high_fuse_o) &&
			$stable(active_ext_fuse_o)) else $error("fuses moved");
	chk_ext_unused:
		assert property (active_ext_fuse_o[7:3] == 5'h1F)
		else $error("ext top bits");
	chk_cal_copy:
		assert property (rc_osc_calibration_o == CAL_BYTE)
		else $error("calibration");
	chk_keep_live:
		assert property (!prog_entered_o && !$past(prog_entered_o, 3) |->
			eeprom_preserve_o == active_high_fuse_o[3]) else $error("preserve");
endmodule

bind ppfi_top ppfi_top_monitor #(.CAL_BYTE(CAL_BYTE)) u_ppfi_top_monitor
(
	.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.output_enable_n_i(output_enable_n_i), .data_oe_n_o(data_oe_n_o),
	.ready_busy_out_o(ready_busy_out_o), .prog_entered_o(prog_entered_o),
	.active_ext_fuse_o(active_ext_fuse_o),
	.active_high_fuse_o(active_high_fuse_o),
	.active_low_fuse_o(active_low_fuse_o),
	.eeprom_preserve_o(eeprom_preserve_o),
	.rc_osc_calibration_o(rc_osc_calibration_o)
);

// ---- test/ppfi_prog_model.sv ----
// Behavioural parallel programmer driving the programming pins
`timescale 1ns/1ps
module ppfi_prog_model
(
	input  wire logic       ref_clk_i,
	input  wire logic       ready_busy_i,
	input  wire logic [7:0] bus_i,
	output logic            load_strobe_o,
	output logic            strobe_action_bit0_o,
	output logic            strobe_action_bit1_o,
	output logic            byte_select_one_o,
	output logic            byte_select_two_o,
	output logic            write_n_o,
	output logic            output_enable_n_o,
	output logic            page_load_pulse_o,
	output logic      [7:0] data_o
);
	int late;
	// Idle levels; the four entry pins rest at 0
	initial
	begin
		late = 0;
		{load_strobe_o, write_n_o, output_enable_n_o} = 3'b011;
		{strobe_action_bit1_o, strobe_action_bit0_o} = 2'b00;
		{byte_select_one_o, byte_select_two_o} = 2'b00;
		page_load_pulse_o = 1'b0;
		data_o = 8'h00;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// Pins settle before the strobe rises so they are sampled clean
	task automatic pulse_load(input logic [1:0] a, input logic [7:0] d);
		{strobe_action_bit1_o, strobe_action_bit0_o} = a;
		data_o = d;
		hold(4);
		load_strobe_o = 1'b1;
		hold(25);
		load_strobe_o = 1'b0;
		hold(2);
		{strobe_action_bit1_o, strobe_action_bit0_o} = 2'b00;
		hold(2);
	endtask
	// Write pulse, then a bounded wait so a stuck busy cannot hang
	task automatic pulse_write(input logic s1, input logic s2);
		{byte_select_one_o, byte_select_two_o} = {s1, s2};
		hold(4);
		write_n_o = 1'b0;
		hold(25);
		write_n_o = 1'b1;
		for (int i = 0; i < 600 && ready_busy_i !== 1'b1; i++)
			hold(1);
		if (ready_busy_i !== 1'b1)
			late++;
		{byte_select_one_o, byte_select_two_o} = 2'b00;
		hold(4);
	endtask
	// Released bus carries the inverse so no stale byte reads back
	task automatic pulse_read(input logic s1, input logic s2,
		output logic [7:0] v);
		{byte_select_one_o, byte_select_two_o} = {s1, s2};
		hold(4);
		output_enable_n_o = 1'b0;
		data_o = ~data_o;
		hold(10);
		v = bus_i;
		output_enable_n_o = 1'b1;
		{byte_select_one_o, byte_select_two_o} = 2'b00;
		hold(4);
	endtask
	task automatic pulse_page;
		page_load_pulse_o = 1'b1;
		hold(25);
		page_load_pulse_o = 1'b0;
		hold(4);
	endtask
endmodule

// ---- test/ppfi_top_tb.sv ----
// Self-checking bench for the parallel programming fuse interface
`timescale 1ns/1ps
module ppfi_top_tb;
	import ppfi_pkg::*;
	// Arbitrary identification and calibration values
	localparam logic [7:0] ID0 = 8'h21;
	localparam logic [7:0] ID1 = 8'h43;
	localparam logic [7:0] ID2 = 8'h65;
	localparam logic [7:0] CAL = 8'h87;
	logic       ref_clk_i, reset_i, prog_mode, serial_mode, ready, entered;
	logic       stb, ax0, ax1, sel1, sel2, wr_n, oe_n, pg_ld, keep_ee;
	logic [7:0] pd, dd, doe_n, bus, fx, fh, fl, cal, lk;
	logic [7:0] fz [3];
	logic [7:0] aw [3];
	int         err_count;
	int         checked;
	// Device wins the bus only while it enables its drivers
	assign bus = (doe_n === 8'h00) ? dd : pd;
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	ppfi_top #(.SIG_MAKER(ID0), .SIG_SIZE(ID1), .SIG_PART(ID2), .CAL_BYTE(CAL))
	u_ppfi_top
	(
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .prog_mode_i(prog_mode),
		.serial_mode_i(serial_mode), .load_strobe_i(stb),
		.strobe_action_bit0_i(ax0), .strobe_action_bit1_i(ax1),
		.byte_select_one_i(sel1), .byte_select_two_i(sel2),
		.write_n_i(wr_n), .output_enable_n_i(oe_n), .page_load_pulse_i(pg_ld),
		.data_i(bus), .data_o(dd), .data_oe_n_o(doe_n),
		.ready_busy_out_o(ready), .prog_entered_o(entered),
		.active_ext_fuse_o(fx), .active_high_fuse_o(fh),
		.active_low_fuse_o(fl), .eeprom_preserve_o(keep_ee),
		.rc_osc_calibration_o(cal)
	);
	ppfi_prog_model u_ppfi_prog_model
	(
		.ref_clk_i(ref_clk_i), .ready_busy_i(ready), .bus_i(bus),
		.load_strobe_o(stb), .strobe_action_bit0_o(ax0),
		.strobe_action_bit1_o(ax1), .byte_select_one_o(sel1),
		.byte_select_two_o(sel2), .write_n_o(wr_n),
		.output_enable_n_o(oe_n), .page_load_pulse_o(pg_ld), .data_o(pd)
	);
	task automatic cmp8(input string s, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic hold(input int n);
		u_ppfi_prog_model.hold(n);
	endtask
	task automatic ld(input logic [1:0] a, input logic [7:0] d);
		u_ppfi_prog_model.pulse_load(a, d);
	endtask
	task automatic wr(input logic s1, input logic s2);
		u_ppfi_prog_model.pulse_write(s1, s2);
	endtask
	task automatic rd(input logic s1, input logic s2, output logic [7:0] v);
		u_ppfi_prog_model.pulse_read(s1, s2, v);
	endtask
	// Extended byte keeps unused bits at 1; serial mode pins bit 5
	function automatic logic [7:0] fuse_exp(input int k,
		input logic [7:0] o, input logic [7:0] v, input logic ser);
		logic [7:0] r;
		r = (k == 2) ? (v | 8'hF8) : v;
		if (k == 1 && ser)
			r[5] = o[5];
		return r;
	endfunction
	function automatic logic [7:0] act(input int k);
		return (k == 0) ? fl : (k == 1) ? fh : fx;
	endfunction
	task automatic mode(input logic m);
		prog_mode = m;
		hold(8);
		aw = fz;
		for (int k = 0; k < 3; k++)
			cmp8("active fuse", fz[k], act(k));
		cmp8("mode", {7'h00, m}, {7'h00, entered});
	endtask
	// Pins carry another byte at the write, so only the latched byte lands
	task automatic fuse_wr(input int k, input logic [7:0] v);
		ld(2'b10, 8'h40);
		ld(2'b01, v);
		ld(2'b11, ~v);
		wr(k == 1, k == 2);
	endtask
	// Idle strobe between command and read must not disturb the command
	task automatic fuse_chk(input int k);
		logic [7:0] v;
		ld(2'b10, 8'h04);
		ld(2'b11, 8'h80);
		rd(k == 1 || k == 3, k >= 2, v);
		cmp8("fuse byte", (k == 3) ? lk : fz[k], v);
	endtask
	task automatic sig_chk(input logic [7:0] a, input logic s1,
		input logic [7:0] e);
		logic [7:0] v;
		ld(2'b10, 8'h08);
		ld(2'b00, a);
		rd(s1, 1'b0, v);
		cmp8("signature", e, v);
	endtask
	// Read reuses the loaded address without reloading it
	task automatic mem_rw(input logic [7:0] wc, input logic [7:0] rc);
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] v;
		a = 8'($urandom);
		d = 8'($urandom);
		ld(2'b10, wc);
		ld(2'b00, a);
		ld(2'b01, d);
		u_ppfi_prog_model.pulse_page();
		wr(1'b0, 1'b0);
		ld(2'b10, rc);
		rd(1'b0, 1'b0, v);
		cmp8("memory", d, v);
	endtask
	// Watchdog far beyond the few thousand cycles the tests need
	initial
	begin
		repeat (40000) @(posedge ref_clk_i);
		err_count++;
		tally_and_finish();
	end
	// Main sequence; pins change on falling edges only
	initial
	begin
		logic [7:0] v;
		{err_count, checked} = {32'h0, 32'h0};
		{reset_i, prog_mode, serial_mode} = 3'b100;
		void'($urandom(32'h039AA522));
		fz = '{8'h62, 8'h99, 8'hFF};
		lk = 8'hFF;
		repeat (8) @(negedge ref_clk_i);
		reset_i = 1'b0;
		hold(3);
		for (int k = 0; k < 3; k++)
			cmp8("reset fuse", fz[k], act(k));
		cmp8("calibration", CAL, cal);
		cmp8("ready", 8'h01, {7'h00, ready});
		$display("test reset done");
		mode(1'b1);
		for (int k = 0; k < 4; k++)
			fuse_chk(k);
		sig_chk(8'h00, 1'b0, ID0);
		sig_chk(8'h01, 1'b0, ID1);
		sig_chk(8'h02, 1'b0, ID2);
		sig_chk(8'h00, 1'b1, CAL);
		$display("test read done");
		for (int n = 0; n < 3; n++)
		begin
			for (int k = 0; k < 3; k++)
			begin
				v = (n == 0) ? 8'h00 : 8'($urandom);
				fuse_wr(k, v);
				fz[k] = fuse_exp(k, fz[k], v, 1'b0);
				fuse_chk(k);
			end
			cmp8("preserve", {7'h00, fz[1][3]}, {7'h00, keep_ee});
			for (int k = 0; k < 3; k++)
				cmp8("held fuse", aw[k], act(k));
			mode(1'b0);
			mode(1'b1);
		end
		$display("test fuse write done");
		serial_mode = 1'b1;
		v = fz[1] ^ 8'h21;
		fuse_wr(1, v);
		fz[1] = fuse_exp(1, fz[1], v, 1'b1);
		fuse_chk(1);
		serial_mode = 1'b0;
		ld(2'b10, 8'h80);
		wr(1'b0, 1'b0);
		for (int k = 0; k < 4; k++)
			fuse_chk(k);
		ld(2'b10, 8'h02);
		ld(2'b00, 8'($urandom));
		rd(1'b0, 1'b0, v);
		cmp8("erased flash", 8'hFF, v);
		mem_rw(8'h10, 8'h02);
		mem_rw(8'h11, 8'h03);
		$display("test erase done");
		ld(2'b10, 8'h20);
		ld(2'b01, 8'hFE);
		ld(2'b11, 8'h01);
		wr(1'b0, 1'b0);
		lk = 8'hFE;
		fuse_chk(3);
		fuse_wr(0, ~fz[0]);
		fuse_chk(0);
		sig_chk(8'h00, 1'b0, ID0);
		// Erase must bring the lock byte back to unprogrammed
		ld(2'b10, 8'h80);
		wr(1'b0, 1'b0);
		lk = 8'hFF;
		fuse_chk(3);
		cmp8("ready waits", 8'h00, u_ppfi_prog_model.late[7:0]);
		$display("test lock done");
		tally_and_finish();
	end
endmodule
